// ==== rtl/dprs_pkg.sv ====
package dprs_pkg;
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int FLAG_SEL_W = 3;
  // Access timing in ns; counts are whole 8 ns cycles, rounded up
  localparam int CLK_PERIOD_NS = 8;
  localparam int ACCESS_NS = 55;
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVER_NS = 10;
  localparam int RECOVER_CYC =
    (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;

  typedef enum logic [1:0] {
    DPRS_OP_MEM_RD = 2'h0,
    DPRS_OP_MEM_WR = 2'h1,
    DPRS_OP_FLAG_RD = 2'h2,
    DPRS_OP_FLAG_WR = 2'h3
  } dprs_op_t;

  typedef struct packed {
    dprs_op_t op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } dprs_req_t;

  typedef struct packed {
    logic sel_n;
    logic flag_space_select_n;
    logic wr_n;
    logic oe_n;
  } dprs_ctl_t;

  localparam dprs_ctl_t CTL_IDLE = '{sel_n: 1'b1, flag_space_select_n: 1'b1,
    wr_n: 1'b1, oe_n: 1'b1};
endpackage : dprs_pkg

// ==== rtl/dprs_host.sv ====
`timescale 1ns/1ns
// Operation
// - Memory access: flag select high, select low
// - Master/slave pin sets busy direction
// - Flag read: flag select low, select high
// - Flag write: strobe write with data bit 0
module dprs_host #(
  parameter int ACCESS_CYCLES = dprs_pkg::ACCESS_CYC,
  parameter int RECOVER_CYCLES = dprs_pkg::RECOVER_CYC,
  parameter bit MASTER = 1'b1
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_req_valid,
  input wire dprs_pkg::dprs_req_t i_req,
  output logic o_req_ready,
  output logic o_rsp_valid,
  output logic [dprs_pkg::DATA_W-1:0] o_rsp_data,
  output logic o_rsp_busy,
  output logic [dprs_pkg::ADDR_W-1:0] o_addr,
  output logic o_sel_n,
  output logic o_flag_space_select_n,
  output logic o_wr_n,
  output logic o_oe_n,
  output logic o_master_sel,
  input wire logic [dprs_pkg::DATA_W-1:0] i_data,
  output logic [dprs_pkg::DATA_W-1:0] o_data,
  output logic o_data_oe,
  input wire logic i_busy_n
);
  // Reads need three access cycles so the synchronised bus has settled
  if (ACCESS_CYCLES < 3 || ACCESS_CYCLES > 200) begin : g_bad_access
    $error("ACCESS_CYCLES out of range");
  end
  if (RECOVER_CYCLES < 1 || RECOVER_CYCLES > 200) begin : g_bad_recover
    $error("RECOVER_CYCLES out of range");
  end

  // ----------------------------------------------------------------------
  // Reset and pin synchronisers
  // ----------------------------------------------------------------------
  logic rst_s1_reg;
  logic rst_n_reg;
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_s1_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n_reg <= rst_s1_reg;
    end
  end
  wire rst_n = rst_n_reg;

  logic [dprs_pkg::DATA_W-1:0] data_s1_reg;
  logic [dprs_pkg::DATA_W-1:0] data_s2_reg;
  logic busy_s1_reg;
  logic busy_s2_reg;
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_s1_reg <= 8'h00;
      data_s2_reg <= 8'h00;
      busy_s1_reg <= 1'b1;
      busy_s2_reg <= 1'b1;
    end else begin
      data_s1_reg <= i_data;
      data_s2_reg <= data_s1_reg;
      busy_s1_reg <= i_busy_n;
      busy_s2_reg <= busy_s1_reg;
    end
  end

  // ----------------------------------------------------------------------
  // Pin sequencer
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    DPRS_IDLE = 3'b001,
    DPRS_ACCESS = 3'b010,
    DPRS_RECOVER = 3'b100
  } dprs_state_t;

  dprs_state_t state_reg;
  dprs_state_t state_next;
  logic [dprs_pkg::CNT_W-1:0] cnt_reg;
  logic [dprs_pkg::CNT_W-1:0] cnt_next;
  dprs_pkg::dprs_req_t req_reg;
  dprs_pkg::dprs_ctl_t ctl_reg;
  dprs_pkg::dprs_ctl_t ctl_next;
  logic busy_seen_reg;

  function automatic dprs_pkg::dprs_ctl_t ctl_for(dprs_pkg::dprs_op_t op);
    dprs_pkg::dprs_ctl_t c;
    c = dprs_pkg::CTL_IDLE;
    unique case (op)
      dprs_pkg::DPRS_OP_MEM_RD: begin
        c.sel_n = 1'b0;
        c.oe_n = 1'b0;
      end
      dprs_pkg::DPRS_OP_MEM_WR: begin
        c.sel_n = 1'b0;
        c.wr_n = 1'b0;
      end
      dprs_pkg::DPRS_OP_FLAG_RD: begin
        c.flag_space_select_n = 1'b0;
        c.oe_n = 1'b0;
      end
      dprs_pkg::DPRS_OP_FLAG_WR: begin
        c.flag_space_select_n = 1'b0;
        c.wr_n = 1'b0;
      end
    endcase
    return c;
  endfunction : ctl_for

  wire take = (state_reg == DPRS_IDLE) && i_req_valid;
  wire cnt_done = (cnt_reg == 8'h00);
  wire is_write = req_reg.op[0];
  wire is_flag = req_reg.op[1];
  // Flag writes carry only data bit 0; the rest is driven low
  function automatic logic [dprs_pkg::DATA_W-1:0] wr_val_for(
    dprs_pkg::dprs_req_t r);
    return r.op[1] ? {7'h00, r.wdata[0]} : r.wdata;
  endfunction : wr_val_for

  // A new request's data goes out with its strobe, never the last one's
  wire [dprs_pkg::DATA_W-1:0] wr_val =
    take ? wr_val_for(i_req) : wr_val_for(req_reg);

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    ctl_next = ctl_reg;
    unique case (state_reg)
      DPRS_IDLE: begin
        if (i_req_valid) begin
          state_next = DPRS_ACCESS;
          cnt_next = 8'(ACCESS_CYCLES - 1);
          ctl_next = ctl_for(i_req.op);
        end
      end
      DPRS_ACCESS: begin
        if (cnt_done) begin
          state_next = DPRS_RECOVER;
          cnt_next = 8'(RECOVER_CYCLES - 1);
          // Both selects back high: port deselected, pins float
          ctl_next = dprs_pkg::CTL_IDLE;
        end else begin
          cnt_next = cnt_reg - 8'h01;
        end
      end
      DPRS_RECOVER: begin
        if (cnt_done) begin
          state_next = DPRS_IDLE;
        end else begin
          cnt_next = cnt_reg - 8'h01;
        end
      end
      default: begin
        state_next = DPRS_IDLE;
        ctl_next = dprs_pkg::CTL_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= DPRS_IDLE;
      cnt_reg <= 8'h00;
      ctl_reg <= dprs_pkg::CTL_IDLE;
      req_reg <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      ctl_reg <= ctl_next;
      if (take) begin
        req_reg <= i_req;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Answers and pins
  // ----------------------------------------------------------------------
  wire access_end = (state_reg == DPRS_ACCESS) && cnt_done;
  // Busy only matters on memory cycles; sampled through the synchroniser
  wire busy_hit = (state_reg == DPRS_ACCESS) && !is_flag && !busy_s2_reg;

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_req_ready <= 1'b0;
      o_rsp_valid <= 1'b0;
      o_rsp_data <= 8'h00;
      o_rsp_busy <= 1'b0;
      busy_seen_reg <= 1'b0;
      o_data <= 8'h00;
      o_data_oe <= 1'b0;
      o_addr <= 13'h0000;
      o_master_sel <= 1'b0;
    end else begin
      o_master_sel <= MASTER;
      o_req_ready <= (state_next == DPRS_IDLE);
      o_rsp_valid <= access_end;
      if (take) begin
        busy_seen_reg <= 1'b0;
      end else if (busy_hit) begin
        busy_seen_reg <= 1'b1;
      end
      if (access_end) begin
        o_rsp_busy <= busy_seen_reg || busy_hit;
        // Flag reads return the flag on all eight lines
        o_rsp_data <= is_write ? 8'h00 : data_s2_reg;
      end
      if (take) begin
        // Flag space uses only A2..A0; upper bits held low
        o_addr <= i_req.op[1] ?
          {10'h000, i_req.addr[dprs_pkg::FLAG_SEL_W-1:0]} : i_req.addr;
      end
      o_data <= wr_val;
      o_data_oe <= (state_next == DPRS_ACCESS) &&
        (take ? i_req.op[0] : is_write);
    end
  end

  assign o_sel_n = ctl_reg.sel_n;
  assign o_flag_space_select_n = ctl_reg.flag_space_select_n;
  assign o_wr_n = ctl_reg.wr_n;
  assign o_oe_n = ctl_reg.oe_n;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_no_dual_select: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    !(!o_sel_n && !o_flag_space_select_n))
    else $error("both selects low");
  a_mem_select_form: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    !o_sel_n |-> o_flag_space_select_n)
    else $error("memory cycle with flag select low");
  a_idle_deselect: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    state_reg == DPRS_RECOVER |-> o_sel_n && o_flag_space_select_n
      && o_wr_n && o_oe_n)
    else $error("strobes active while deselected");
  a_no_drive_read: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    !o_oe_n |-> !o_data_oe)
    else $error("host drives bus during read");
  a_write_drives: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    !o_wr_n |-> o_data_oe && o_oe_n)
    else $error("write without data drive");
  a_flag_bit_only: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    !o_flag_space_select_n && o_data_oe |-> o_data[7:1] == 7'h00)
    else $error("flag write upper bits set");
  a_flag_addr_low: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    !o_flag_space_select_n |-> o_addr[12:3] == 10'h000)
    else $error("flag address upper bits set");
  a_answer_after: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    take |-> ##[1:201] o_rsp_valid)
    else $error("no answer to request");
  a_master_pin: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    $past(rst_n) |-> o_master_sel == MASTER)
    else $error("master select wrong");
  a_busy_report: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    busy_hit && !access_end |=> busy_seen_reg)
    else $error("busy not latched");

  c_mem_read: cover property (@(posedge i_ref_clk)
    take && i_req.op == dprs_pkg::DPRS_OP_MEM_RD);
  c_mem_write: cover property (@(posedge i_ref_clk)
    take && i_req.op == dprs_pkg::DPRS_OP_MEM_WR);
  c_flag_write: cover property (@(posedge i_ref_clk)
    take && i_req.op == dprs_pkg::DPRS_OP_FLAG_WR);
  c_busy_answer: cover property (@(posedge i_ref_clk)
    o_rsp_valid && o_rsp_busy);
endmodule : dprs_host

// ==== tb/dprs_dev_model.sv ====
`timescale 1ns/1ns
// ---------------------------------------------
// One port of the shared memory with its flags
// ---------------------------------------------
module dprs_dev_model (
  input wire logic [dprs_pkg::ADDR_W-1:0] i_addr,
  input wire logic i_sel_n,
  input wire logic i_flag_space_select_n,
  input wire logic i_wr_n,
  input wire logic i_oe_n,
  input wire logic i_master_sel,
  input wire logic [dprs_pkg::DATA_W-1:0] i_host_d,
  input wire logic i_host_oe,
  input wire logic i_contend,
  output logic [dprs_pkg::DATA_W-1:0] o_bus,
  output logic o_busy_n
);
  logic [7:0] mem [8192];
  logic [7:0] flag = 8'h00;
  logic [7:0] last = 8'h00;
  logic wr_mem = 1'b0;
  logic wr_flg = 1'b0;
  wire mem_on = !i_sel_n && i_flag_space_select_n;
  wire flg_on = i_sel_n && !i_flag_space_select_n;
  wire rd_on = (mem_on || flg_on) && i_wr_n && !i_oe_n;
  wire [7:0] q = mem_on ? mem[i_addr] : {8{flag[i_addr[2:0]]}};
  // Writes land on the trailing edge of the strobe, once address and
  // data have settled; the kind of cycle is noted after the strobe falls
  always @(negedge i_wr_n) begin
    #1;
    wr_mem = mem_on;
    wr_flg = flg_on;
  end
  always @(posedge i_wr_n) begin
    if (wr_mem) mem[i_addr] = i_host_d;
    if (wr_flg) flag[i_addr[2:0]] = i_host_d[0];
    wr_mem = 1'b0;
    wr_flg = 1'b0;
  end
  // Released bus shows the inverse, so a stale sample cannot match
  always @* begin
    if (i_host_oe) last = i_host_d;
    else if (rd_on) last = q;
  end
  assign o_bus = i_host_oe ? i_host_d : (rd_on ? q : ~last);
  assign o_busy_n = !(i_master_sel && i_contend && mem_on);
endmodule : dprs_dev_model

// ==== tb/dprs_host_tb.sv ====
`timescale 1ns/1ns
module dprs_host_tb;
  logic clk = 1'b0, rst_n = 1'b0, vld = 1'b0, contend = 1'b0;
  dprs_pkg::dprs_req_t req = '0;
  logic [7:0] bus, od, rd, q;
  logic [12:0] a;
  logic sn, fn, wn, on, ms, doe, rdy, rv, rb, bn, bz;
  int err_count = 0, samples_checked = 0;
  initial forever #4 clk = ~clk;
  dprs_host dprs_host_i (.i_ref_clk(clk), .i_rst_n(rst_n),
    .i_req_valid(vld), .i_req(req), .o_req_ready(rdy), .o_rsp_valid(rv),
    .o_rsp_data(rd), .o_rsp_busy(rb), .o_addr(a), .o_sel_n(sn),
    .o_flag_space_select_n(fn), .o_wr_n(wn), .o_oe_n(on),
    .o_master_sel(ms), .i_data(bus), .o_data(od), .o_data_oe(doe),
    .i_busy_n(bn));
  dprs_dev_model dprs_dev_model_i (.i_addr(a), .i_sel_n(sn),
    .i_flag_space_select_n(fn), .i_wr_n(wn), .i_oe_n(on),
    .i_master_sel(ms), .i_host_d(od), .i_host_oe(doe),
    .i_contend(contend), .o_bus(bus), .o_busy_n(bn));
  // ---------------------------------------------
  // Shared tasks
  // ---------------------------------------------
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic xfer(input dprs_pkg::dprs_op_t op, input logic [12:0] ad,
    input logic [7:0] wd);
    int n;
    logic [12:0] ea;
    logic [3:0] es;
    n = 0;
    ea = op[1] ? {10'h000, ad[2:0]} : ad;
    es = op[1] ? (op[0] ? 4'h9 : 4'hA) : (op[0] ? 4'h5 : 4'h6);
    @(negedge clk);
    while (rdy !== 1'b1 && n < 40) begin
      n++;
      @(negedge clk);
    end
    chk({2'h0, rdy, sn, fn, wn, on, doe}, 8'h3E);
    req = '{op: op, addr: ad, wdata: wd};
    vld = 1'b1;
    @(negedge clk);
    vld = 1'b0;
    chk({4'h0, sn, fn, wn, on}, {4'h0, es});
    chk(a[7:0], ea[7:0]);
    chk({3'h0, a[12:8]}, {3'h0, ea[12:8]});
    chk({7'h00, doe}, {7'h00, op[0]});
    if (op[0]) chk(od, op[1] ? {7'h00, wd[0]} : wd);
    n = 0;
    while (rv !== 1'b1 && n < 40) begin
      n++;
      @(negedge clk);
    end
    chk({7'h00, rv}, 8'h01);
    q = rd;
    bz = rb;
  endtask : xfer
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim
  // ---------------------------------------------
  // Scenarios
  // ---------------------------------------------
  task automatic t_mem;
    logic [12:0] adr [3];
    adr = '{13'h0000, 13'h1FFF, 13'h0AAA};
    foreach (adr[i]) begin
      xfer(dprs_pkg::DPRS_OP_MEM_WR, adr[i], adr[i][7:0] ^ 8'h5C);
    end
    foreach (adr[i]) begin
      xfer(dprs_pkg::DPRS_OP_MEM_RD, adr[i], 8'h00);
      chk(q, adr[i][7:0] ^ 8'h5C);
      chk({7'h00, bz}, 8'h00);
    end
    chk({7'h00, ms}, 8'h01);
    $display("t_mem done");
  endtask : t_mem
  task automatic t_flag;
    xfer(dprs_pkg::DPRS_OP_FLAG_WR, 13'h1FFF, 8'h01);
    xfer(dprs_pkg::DPRS_OP_FLAG_RD, 13'h0007, 8'h00);
    chk(q, 8'hFF);
    xfer(dprs_pkg::DPRS_OP_FLAG_RD, 13'h0006, 8'h00);
    chk(q, 8'h00);
    xfer(dprs_pkg::DPRS_OP_FLAG_WR, 13'h0007, 8'hFE);
    xfer(dprs_pkg::DPRS_OP_FLAG_RD, 13'h0007, 8'h00);
    chk(q, 8'h00);
    xfer(dprs_pkg::DPRS_OP_MEM_RD, 13'h1FFF, 8'h00);
    chk(q, 8'hA3);
    $display("t_flag done");
  endtask : t_flag
  task automatic t_busy;
    @(negedge clk);
    contend = 1'b1;
    xfer(dprs_pkg::DPRS_OP_MEM_WR, 13'h0100, 8'h3C);
    chk({7'h00, bz}, 8'h01);
    contend = 1'b0;
    xfer(dprs_pkg::DPRS_OP_MEM_WR, 13'h0100, 8'hC3);
    chk({7'h00, bz}, 8'h00);
    $display("t_busy done");
  endtask : t_busy
  // Host must never select memory and flags together
  always @(negedge clk) begin
    if (rst_n && !sn && !fn) begin
      err_count++;
      $display("MISMATCH %0t both selects low", $time);
    end
  end
  initial begin
    #6000;
    err_count++;
    $display("MISMATCH %0t watchdog expired", $time);
    end_sim;
  end
  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    t_mem;
    t_flag;
    t_busy;
    end_sim;
  end
endmodule : dprs_host_tb
